// [core/bcms_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Reset, clock mask and power state sequencing for a two-port bus bridge.
module bcms_sequencer (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_clock_mask_serial_in,
  input wire logic i_secondary_clock_source,
  input wire logic i_bus_power_clock_control_pin,
  input wire logic [3:0] i_gpio,
  output logic [3:0] o_gpio,
  output logic [3:0] o_gpio_oe,
  output logic [9:0] o_secondary_clock_outputs,
  output logic o_secondary_rst_n,
  output logic o_pri_if_oe,
  output logic o_sec_ctrl_oe,
  output logic o_sec_ad_drive_low,
  output logic o_buffer_flush,
  output logic o_cfg_ready,
  output logic o_io_enable,
  output logic o_mem_enable,
  output logic o_master_enable,
  output logic o_return_delayed_completions
);

  // ==========================================================================
  // Reset release synchroniser and pin synchronisers.
  logic [1:0] rel_reg;
  logic prim_rel;
  logic mask_bit_sync;
  logic sclk_sync;
  logic bpcc_sync;
  logic [3:0] gpio_sync;

  // Flops take only constants under reset; release reaches logic two edges late.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rel_reg <= 2'b00;
    end else begin
      rel_reg <= {rel_reg[0], 1'b1};
    end
  end
  assign prim_rel = rel_reg[1];

  bcms_sync #(.WIDTH(7)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_clock_mask_serial_in, i_secondary_clock_source,
      i_bus_power_clock_control_pin, i_gpio}),
    .o_sync({mask_bit_sync, sclk_sync, bpcc_sync, gpio_sync})
  );

  // ==========================================================================
  // Registers.
  bcms_pkg::bcms_seq_t seq_reg;
  bcms_pkg::bcms_seq_t seq_next;
  logic [2:0] cmd_reg;
  logic sec_bit_reg;
  logic chip_bit_reg;
  logic live_mode_reg;
  logic [15:0] clk_mask_reg;
  logic [3:0] gpio_oe_reg;
  logic [3:0] gpio_out_reg;
  logic [1:0] pm_reg;
  logic [4:0] boot_cnt_reg;
  logic [4:0] chip_cnt_reg;
  logic soft_rst_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic pri_oe_reg;
  logic sec_oe_reg;
  logic [9:0] sclk_out_reg;

  logic sh_busy;
  logic sh_done;
  logic sh_clk;
  logic sh_ctrl;
  logic [15:0] sh_mask;

  localparam logic [4:0] BOOT_LAST = 5'(bcms_pkg::BOOT_BLOCK_CLKS);
  localparam logic [4:0] CHIP_LAST = 5'(bcms_pkg::CHIP_CLR_CLKS);

  // ==========================================================================
  // Bus decode.
  wire ready = (boot_cnt_reg == BOOT_LAST);
  wire req = i_wb_cyc && i_wb_stb && !ack_reg && ready;
  wire wr = i_wb_cyc && i_wb_stb && ack_reg && i_wb_we; // Commit at the edge that shows ack.
  wire wr_lo = wr && i_wb_sel[0];
  wire wr_cmd = wr_lo && (i_wb_adr == bcms_pkg::REG_CMD);
  wire wr_bctl = wr_lo && (i_wb_adr == bcms_pkg::REG_BRIDGE_CTRL);
  wire wr_chip = wr_lo && (i_wb_adr == bcms_pkg::REG_CHIP_CTRL);
  wire wr_mask = wr && (i_wb_adr == bcms_pkg::REG_CLK_MASK);
  wire wr_oe = wr_lo && (i_wb_adr == bcms_pkg::REG_GPIO_OE);
  wire wr_out = wr_lo && (i_wb_adr == bcms_pkg::REG_GPIO_OUT);
  wire wr_pm = wr_lo && (i_wb_adr == bcms_pkg::REG_PM_CSR);
  wire [1:0] pm_req = i_wb_dat[1:0];
  wire chip_set = wr_chip && i_wb_dat[bcms_pkg::CHIP_RST_BIT] && !chip_bit_reg;
  wire pm_wake = wr_pm && (pm_reg == bcms_pkg::PM_D3HOT) && (pm_req == bcms_pkg::PM_D0);
  wire sec_set = wr_bctl && i_wb_dat[bcms_pkg::BCTL_SEC_RST_BIT] && !sec_bit_reg;
  wire shift_start = (seq_reg != bcms_pkg::SEQ_SHIFT) && (seq_next == bcms_pkg::SEQ_SHIFT);

  // ==========================================================================
  // Live insertion halt and effective enables.
  wire live_halt = live_mode_reg && !gpio_oe_reg[bcms_pkg::GPIO_LIVE_PIN]
    && gpio_sync[bcms_pkg::GPIO_LIVE_PIN];
  wire [2:0] eff_en = live_halt ? 3'h0 : cmd_reg;
  wire sec_rst_active = !prim_rel || sec_bit_reg || chip_bit_reg
    || (seq_reg != bcms_pkg::SEQ_RUN);
  wire d3_stop = (pm_reg == bcms_pkg::PM_D3HOT) && bpcc_sync;

  // ==========================================================================
  // Sequencer next state: boot wait, mask shift, running.
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      bcms_pkg::SEQ_BOOT: begin
        if (prim_rel) begin
          seq_next = bcms_pkg::SEQ_SHIFT;
        end
      end
      bcms_pkg::SEQ_SHIFT: begin
        if (sh_done) begin
          seq_next = bcms_pkg::SEQ_RUN;
        end
      end
      default: begin
        if (chip_set || sec_set) begin
          seq_next = bcms_pkg::SEQ_SHIFT;
        end
      end
    endcase
  end

  bcms_mask_shift u_shift (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_start(shift_start),
    .i_mask_bit(mask_bit_sync),
    .o_busy(sh_busy),
    .o_done(sh_done),
    .o_shift_clk(sh_clk),
    .o_shift_ctrl(sh_ctrl),
    .o_mask(sh_mask)
  );

  // Sequencing, boot block counter and chip reset self clear.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seq_reg <= bcms_pkg::SEQ_BOOT;
      boot_cnt_reg <= 5'h00;
      chip_cnt_reg <= 5'h00;
      soft_rst_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      if (prim_rel && !ready) begin
        boot_cnt_reg <= boot_cnt_reg + 5'h01;
      end
      soft_rst_reg <= chip_set || pm_wake;
      if (chip_bit_reg && !sec_bit_reg && (seq_reg == bcms_pkg::SEQ_RUN)) begin
        chip_cnt_reg <= chip_cnt_reg + 5'h01;
      end else begin
        chip_cnt_reg <= 5'h00;
      end
    end
  end

  // Configuration registers; a soft reset restores defaults, but the chip bit holds and the secondary bit copies it, and it also drops o_pri_if_oe.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_reg <= bcms_pkg::CMD_RST;
      sec_bit_reg <= 1'b0;
      chip_bit_reg <= 1'b0;
      live_mode_reg <= 1'b0;
      clk_mask_reg <= bcms_pkg::CLK_MASK_RST;
      gpio_oe_reg <= bcms_pkg::GPIO_RST;
      gpio_out_reg <= bcms_pkg::GPIO_RST;
      pm_reg <= bcms_pkg::PM_D0;
    end else if (soft_rst_reg) begin
      cmd_reg <= bcms_pkg::CMD_RST;
      sec_bit_reg <= chip_bit_reg;
      live_mode_reg <= 1'b0;
      clk_mask_reg <= bcms_pkg::CLK_MASK_RST;
      gpio_oe_reg <= bcms_pkg::GPIO_RST;
      gpio_out_reg <= bcms_pkg::GPIO_RST;
      pm_reg <= bcms_pkg::PM_D0;
    end else begin
      if (wr_cmd) begin
        cmd_reg <= i_wb_dat[2:0];
      end
      if (chip_set) begin
        sec_bit_reg <= 1'b1;
      end else if (wr_bctl) begin
        sec_bit_reg <= i_wb_dat[bcms_pkg::BCTL_SEC_RST_BIT];
      end
      if (chip_set) begin
        chip_bit_reg <= 1'b1;
      end else if (chip_cnt_reg >= CHIP_LAST) begin
        chip_bit_reg <= 1'b0;
      end
      if (wr_chip) begin
        live_mode_reg <= i_wb_dat[bcms_pkg::CHIP_LIVE_MODE_BIT];
      end
      // A shift result wins over a software write landing in the same cycle.
      if (sh_done) begin
        clk_mask_reg <= sh_mask;
      end else if (wr_mask) begin
        if (i_wb_sel[0]) begin
          clk_mask_reg[7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          clk_mask_reg[15:8] <= i_wb_dat[15:8];
        end
      end
      if (wr_oe) begin
        gpio_oe_reg <= (gpio_oe_reg | i_wb_dat[bcms_pkg::GPIO_SET_LSB +: 4])
          & ~i_wb_dat[bcms_pkg::GPIO_CLR_LSB +: 4];
      end
      if (wr_out) begin
        gpio_out_reg <= (gpio_out_reg | i_wb_dat[bcms_pkg::GPIO_SET_LSB +: 4])
          & ~i_wb_dat[bcms_pkg::GPIO_CLR_LSB +: 4];
      end
      if (wr_pm && (pm_req == bcms_pkg::PM_D3HOT)) begin
        pm_reg <= bcms_pkg::PM_D3HOT;
      end
      // Requests for D1 or D2 fall through and leave the state alone.
    end
  end

  // ==========================================================================
  // Read data and acknowledge.
  wire [31:0] rd_word =
    (i_wb_adr == bcms_pkg::REG_CMD) ? {29'h0, cmd_reg} :
    (i_wb_adr == bcms_pkg::REG_BRIDGE_CTRL) ? {31'h0, sec_bit_reg} :
    (i_wb_adr == bcms_pkg::REG_CHIP_CTRL) ? {30'h0, live_mode_reg, chip_bit_reg} :
    (i_wb_adr == bcms_pkg::REG_CLK_MASK) ? {16'h0, clk_mask_reg} :
    (i_wb_adr == bcms_pkg::REG_GPIO_OE) ? {28'h0, gpio_oe_reg} :
    (i_wb_adr == bcms_pkg::REG_GPIO_OUT) ? {28'h0, gpio_out_reg} :
    (i_wb_adr == bcms_pkg::REG_GPIO_IN) ? {28'h0, gpio_sync} :
    (i_wb_adr == bcms_pkg::REG_PM_CSR) ? {30'h0, pm_reg} :
    (i_wb_adr == bcms_pkg::REG_STATUS) ? {25'h0, eff_en, (seq_reg == bcms_pkg::SEQ_RUN),
      live_halt, sec_rst_active, sh_busy} : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      if (req && !i_wb_we) begin
        rdat_reg <= rd_word;
      end
    end
  end
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // ==========================================================================
  // Secondary clock gating: pairs for slots, single bits for devices.
  logic [9:0] clk_en;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_slot
      assign clk_en[g] = !(clk_mask_reg[2*g] && clk_mask_reg[2*g+1]);
    end
    for (g = 4; g < 9; g++) begin : g_dev
      assign clk_en[g] = !clk_mask_reg[g+4];
    end
  endgenerate
  assign clk_en[9] = !clk_mask_reg[13];

  // Output drivers; primary and secondary enables drop at once on reset.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_out_reg <= 10'h3ff;
      pri_oe_reg <= 1'b0;
      sec_oe_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 10; i++) begin
        sclk_out_reg[i] <= d3_stop ? 1'b0 : (clk_en[i] ? sclk_sync : 1'b1);
      end
      pri_oe_reg <= prim_rel && !chip_bit_reg && !soft_rst_reg;
      sec_oe_reg <= !sec_rst_active;
    end
  end

  // Shift control owns pins 0 and 2 while busy; the rest stay tri-stated then.
  assign o_gpio[0] = sh_busy ? sh_clk : gpio_out_reg[0];
  assign o_gpio[1] = gpio_out_reg[1];
  assign o_gpio[2] = sh_busy ? sh_ctrl : gpio_out_reg[2];
  assign o_gpio[3] = gpio_out_reg[3];
  assign o_gpio_oe = sh_busy ? 4'h5 : gpio_oe_reg;
  assign o_secondary_clock_outputs = sclk_out_reg;
  assign o_secondary_rst_n = !sec_rst_active;
  assign o_pri_if_oe = pri_oe_reg;
  assign o_sec_ctrl_oe = sec_oe_reg;
  assign o_sec_ad_drive_low = sec_rst_active;
  assign o_buffer_flush = sec_rst_active;
  assign o_cfg_ready = ready;
  assign {o_master_enable, o_mem_enable, o_io_enable} = eff_en;
  assign o_return_delayed_completions = !live_halt;

  // ==========================================================================
  // Checks.
  AST_SHIFT_HOLDS_RST: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (seq_reg == bcms_pkg::SEQ_SHIFT) |-> !o_secondary_rst_n)
    else $error("Secondary reset released during mask shift.");

  AST_BIT_HOLDS_RST: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sec_bit_reg |-> ##1 (!o_secondary_rst_n || !sec_bit_reg))
    else $error("Secondary reset released while its bit is set.");

  AST_BOOT_BLOCK: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(o_cfg_ready) |-> ($past(prim_rel, 16) && !$past(prim_rel, 17)))
    else $error("Configuration access opened at the wrong time.");

  AST_D1D2_IGNORED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (wr_pm && (pm_reg == bcms_pkg::PM_D0) && (pm_req == bcms_pkg::PM_D1
      || pm_req == bcms_pkg::PM_D2)) |=> (pm_reg == bcms_pkg::PM_D0))
    else $error("Power state left D0 on a D1 or D2 request.");

  AST_LIVE_RESTORE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(live_halt) |-> ({o_master_enable, o_mem_enable, o_io_enable} == cmd_reg))
    else $error("Enables not restored after live insertion halt.");

  AST_CLK_HELD_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !o_secondary_clock_outputs[8] |-> ($past(d3_stop) || !$past(clk_mask_reg[12])))
    else $error("Disabled secondary clock went low.");

  AST_D3_LOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    d3_stop |=> (o_secondary_clock_outputs == 10'h000))
    else $error("Secondary clocks not stopped low in D3hot.");

  AST_CHIP_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (chip_bit_reg && !sec_bit_reg && (seq_reg == bcms_pkg::SEQ_RUN) && !chip_set)
      |-> ##[1:20] !chip_bit_reg)
    else $error("Chip reset bit did not self clear within 20 clocks.");

endmodule // bcms_sequencer

`default_nettype wire

// [core/bcms_pkg.sv]
package bcms_pkg;

  // ==========================================================================
  // Clock rates and timing.
  localparam int CORE_CLK_MHZ = 100;
  localparam int SHIFT_CLK_MAX_MHZ = 33;
  // Core cycles per shift clock period, rounded up so the rate stays at or below the maximum.
  localparam int SHIFT_DIV = (CORE_CLK_MHZ + SHIFT_CLK_MAX_MHZ - 1) / SHIFT_CLK_MAX_MHZ;
  localparam int SHIFT_PERIODS = 23;
  localparam int MASK_BITS = 16;
  localparam int BOOT_BLOCK_CLKS = 16;
  localparam int CHIP_CLR_MAX_CLKS = 20;
  localparam int CHIP_CLR_CLKS = 4;

  // ==========================================================================
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_BRIDGE_CTRL = 8'h08;
  localparam logic [7:0] REG_CHIP_CTRL = 8'h0c;
  localparam logic [7:0] REG_CLK_MASK = 8'h10;
  localparam logic [7:0] REG_GPIO_OE = 8'h14;
  localparam logic [7:0] REG_GPIO_OUT = 8'h18;
  localparam logic [7:0] REG_GPIO_IN = 8'h1c;
  localparam logic [7:0] REG_PM_CSR = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;

  // ==========================================================================
  // Field positions and reset values.
  localparam int BCTL_SEC_RST_BIT = 0;
  localparam int CHIP_RST_BIT = 0;
  localparam int CHIP_LIVE_MODE_BIT = 1;
  localparam int GPIO_SET_LSB = 0;
  localparam int GPIO_CLR_LSB = 4;
  localparam int GPIO_SHIFT_CLK_PIN = 0;
  localparam int GPIO_SHIFT_CTRL_PIN = 2;
  localparam int GPIO_LIVE_PIN = 3;
  localparam logic [2:0] CMD_RST = 3'h0;
  localparam logic [15:0] CLK_MASK_RST = 16'h0000;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam logic [1:0] PM_D0 = 2'h0;
  localparam logic [1:0] PM_D1 = 2'h1;
  localparam logic [1:0] PM_D2 = 2'h2;
  localparam logic [1:0] PM_D3HOT = 2'h3;

  // ==========================================================================
  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_BOOT,
    SEQ_SHIFT,
    SEQ_RUN
  } bcms_seq_t;

endpackage

// [core/bcms_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-flop synchroniser for signals entering the core clock domain.
module bcms_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // bcms_sync

`default_nettype wire

// [core/bcms_mask_shift.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Drives the external mask shift register and collects the serial mask word.
module bcms_mask_shift (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_mask_bit,
  output logic o_busy,
  output logic o_done,
  output logic o_shift_clk,
  output logic o_shift_ctrl,
  output logic [bcms_pkg::MASK_BITS-1:0] o_mask
);

  localparam logic [7:0] DIV_LAST = 8'(bcms_pkg::SHIFT_DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(bcms_pkg::SHIFT_DIV / 2);
  localparam logic [7:0] PER_LAST = 8'(bcms_pkg::SHIFT_PERIODS - 1);
  localparam logic [7:0] BITS = 8'(bcms_pkg::MASK_BITS);

  logic busy_reg;
  logic done_reg;
  logic [7:0] phase_reg;
  logic [7:0] period_reg;
  logic [7:0] bit_cnt_reg;
  logic [bcms_pkg::MASK_BITS-1:0] mask_reg;
  wire period_end = busy_reg && (phase_reg == DIV_LAST);
  // Sample just before the rising edge, when the synchronised bit has settled.
  wire sample = busy_reg && (period_reg != 8'h00) && (phase_reg == DIV_HALF - 8'h01)
    && (bit_cnt_reg < BITS);

  // Period 0 loads, the rest shift; 23 periods in all, 16 of them sampled.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      phase_reg <= 8'h00;
      period_reg <= 8'h00;
      bit_cnt_reg <= 8'h00;
      mask_reg <= bcms_pkg::CLK_MASK_RST;
    end else begin
      done_reg <= period_end && (period_reg == PER_LAST);
      if (i_start && !busy_reg) begin
        busy_reg <= 1'b1;
        phase_reg <= 8'h00;
        period_reg <= 8'h00;
        bit_cnt_reg <= 8'h00;
      end else if (period_end) begin
        phase_reg <= 8'h00;
        period_reg <= period_reg + 8'h01;
        if (period_reg == PER_LAST) begin
          busy_reg <= 1'b0;
        end
      end else if (busy_reg) begin
        phase_reg <= phase_reg + 8'h01;
      end
      if (sample) begin
        mask_reg <= {mask_reg[bcms_pkg::MASK_BITS-2:0], i_mask_bit};
        bit_cnt_reg <= bit_cnt_reg + 8'h01;
      end
    end
  end

  // Clock is low for the first half of each period, so its rate is core / 4.
  assign o_shift_clk = busy_reg && (phase_reg >= DIV_HALF);
  assign o_shift_ctrl = busy_reg && (period_reg != 8'h00);
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_mask = mask_reg;

  sequence s_load_then_shift;
    (!o_shift_ctrl) [*4] ##1 o_shift_ctrl;
  endsequence

  AST_LOAD_ONE_PERIOD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_start && !busy_reg) |=> s_load_then_shift)
    else $error("Load phase did not last exactly one shift period.");

  AST_CLK_RATE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(o_shift_clk) |=> !$rose(o_shift_clk) ##1 !$rose(o_shift_clk)
      ##1 !$rose(o_shift_clk))
    else $error("Shift clock rose faster than its maximum rate.");

  AST_SEQ_LENGTH: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_start && !busy_reg) |-> ##93 o_done)
    else $error("Mask shift did not finish after 23 shift periods.");

  AST_SIXTEEN_BITS: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_done |-> (bit_cnt_reg == BITS))
    else $error("Mask shift did not capture exactly 16 bits.");

endmodule // bcms_mask_shift

`default_nettype wire

// [bench/bcms_shreg_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Parallel-load shift register that holds the clock mask word.
module bcms_shreg_model #(
  parameter logic [15:0] WORD = 16'h2a5c
) (
  input wire logic i_clk,
  input wire logic i_load_n,
  output logic o_ser
);
  logic [15:0] sh_reg = 16'h0000;
  // Low control loads the word; high shifts it up, so ones fill once it is spent.
  always @(posedge i_clk) begin
    sh_reg <= i_load_n ? {sh_reg[14:0], 1'b1} : WORD;
  end
  assign o_ser = sh_reg[15];
endmodule // bcms_shreg_model

`default_nettype wire

// [bench/bcms_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end

// ============================================================================
// Bench for the reset and clock mask sequencer.
module bcms_sequencer_bench;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, src = 0, run = 0, bpc = 1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, q;
  logic [3:0] drv = 4'h4, gp, oe;
  logic [9:0] sclk;
  logic ack, srn, ser, pri, sec, adl, fl, rdy, ioe, mme, mse, dly;
  wire logic [3:0] pins;
  int errors = 0, comparisons = 0, tick = 0, k;
  logic [15:0] row_m [8] = '{16'h0000, 16'hffff, 16'h0003, 16'h00c0, 16'h0100, 16'h1000,
    16'h2000, 16'hc000};
  logic [9:0] row_c [8] = '{10'h000, 10'h3ff, 10'h001, 10'h008, 10'h010, 10'h100, 10'h200,
    10'h000};

  // Core clock, and the 80 ns source clock that only runs when asked.
  always #5 clk = ~clk;
  always #40 src = run ? ~src : 1'b0;
  // Pin levels: the design where it drives, else the bench's pull values.
  assign pins = (gp & oe) | (drv & ~oe);

  bcms_shreg_model shreg (.i_clk(pins[0]), .i_load_n(pins[2]), .o_ser(ser));
  bcms_sequencer dut (.i_core_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(q),
    .o_wb_ack(ack), .i_clock_mask_serial_in(ser), .i_secondary_clock_source(src),
    .i_bus_power_clock_control_pin(bpc), .i_gpio(pins), .o_gpio(gp), .o_gpio_oe(oe),
    .o_secondary_clock_outputs(sclk), .o_secondary_rst_n(srn), .o_pri_if_oe(pri),
    .o_sec_ctrl_oe(sec), .o_sec_ad_drive_low(adl), .o_buffer_flush(fl), .o_cfg_ready(rdy),
    .o_io_enable(ioe), .o_mem_enable(mme), .o_master_enable(mse),
    .o_return_delayed_completions(dly));

  // One classic cycle; entered just after an edge, held until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    tick++;
    if (tick == 6000) begin
      errors++;
      conclude();
    end
  end

  // Boot shift, mask table, then power, live halt and reset cases.
  initial begin
    repeat (2) @(posedge clk);
    `CHK({srn, pri, oe}, 6'h0)
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK({oe, gp[2]}, 5'h0a)
    repeat (7) @(posedge clk);
    `CHK({rdy, gp[2]}, 2'b01)
    repeat (58) @(posedge clk);
    `CHK(srn, 1'b0)
    repeat (40) @(posedge clk);
    `CHK({srn, sec, oe}, 6'h30)
    wb(1'b0, bcms_pkg::REG_CLK_MASK, 32'h0);
    `CHK(rd, 32'h2a5c)
    wb(1'b0, 8'hfc, 32'h0);
    `CHK(rd, 32'h0)
    foreach (row_m[i]) begin
      wb(1'b1, bcms_pkg::REG_CLK_MASK, {16'h0, row_m[i]});
      repeat (4) @(posedge clk);
      `CHK(sclk, row_c[i])
    end
    run = 1'b1;
    k = 0;
    repeat (30) @(posedge clk) k += int'(sclk[9] === 1'b1);
    `CHK(k > 0 && k < 30, 1'b1)
    run = 1'b0;
    for (int p = 1; p < 3; p++) begin
      wb(1'b1, bcms_pkg::REG_PM_CSR, p);
      wb(1'b0, bcms_pkg::REG_PM_CSR, 32'h0);
      `CHK(rd[1:0], bcms_pkg::PM_D0)
    end
    wb(1'b1, bcms_pkg::REG_CLK_MASK, 32'hffff);
    wb(1'b1, bcms_pkg::REG_PM_CSR, 32'h3);
    repeat (4) @(posedge clk);
    `CHK(sclk, 10'h000)
    wb(1'b1, bcms_pkg::REG_PM_CSR, 32'h0);
    wb(1'b0, bcms_pkg::REG_CLK_MASK, 32'h0);
    `CHK({srn, rd}, 33'h100000000)
    wb(1'b1, bcms_pkg::REG_CMD, 32'h7);
    wb(1'b1, bcms_pkg::REG_CHIP_CTRL, 32'h2);
    drv <= 4'hc;
    repeat (4) @(posedge clk);
    `CHK({ioe, mme, mse, dly}, 4'h0)
    wb(1'b0, bcms_pkg::REG_CMD, 32'h0);
    `CHK(rd[2:0], 3'h7)
    drv <= 4'h4;
    repeat (4) @(posedge clk);
    `CHK({ioe, mme, mse}, 3'h7)
    wb(1'b1, bcms_pkg::REG_BRIDGE_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK({srn, sec, adl, fl}, 4'h3)
    wb(1'b0, bcms_pkg::REG_BRIDGE_CTRL, 32'h0);
    `CHK(rd[0], 1'b1)
    wb(1'b1, bcms_pkg::REG_BRIDGE_CTRL, 32'h0);
    repeat (110) @(posedge clk);
    `CHK(srn, 1'b1)
    wb(1'b1, bcms_pkg::REG_CHIP_CTRL, 32'h1);
    repeat (120) @(posedge clk);
    wb(1'b0, bcms_pkg::REG_BRIDGE_CTRL, 32'h0);
    `CHK(rd[0], 1'b1)
    wb(1'b1, bcms_pkg::REG_BRIDGE_CTRL, 32'h0);
    repeat (120) @(posedge clk);
    wb(1'b0, bcms_pkg::REG_CHIP_CTRL, 32'h0);
    `CHK(rd[0], 1'b0)
    // Set two pin drivers, then clear one of them again.
    wb(1'b1, bcms_pkg::REG_GPIO_OE, 32'h5);
    wb(1'b1, bcms_pkg::REG_GPIO_OE, 32'h10);
    `CHK(oe, 4'h4)
    // A second primary reset in mid-run must drop the secondary reset, ready and output enables at once.
    rstn <= 1'b0;
    @(posedge clk);
    `CHK({srn, pri, sec, rdy, oe}, 8'h00)
    rstn <= 1'b1;
    repeat (16) @(posedge clk);
    `CHK(rdy, 1'b0)
    repeat (4) @(posedge clk);
    `CHK(rdy, 1'b1)
    conclude();
  end
endmodule // bcms_sequencer_bench

`default_nettype wire
